// ===== src/vpd_plane_datapath.sv
// graphics controller plane datapath: registers, write path, read path, serializer
`timescale 1ns/1ps
module vpd_plane_datapath (
   input  wire logic                  mclk_i,
   input  wire logic                  rst_b_i,
   input  vpd_pkg::vpd_host_cyc_t     reg_cyc_i,         // register port cycle
   output logic [7:0]                 reg_rdata_o,       // register read data
   input  vpd_pkg::vpd_host_cyc_t     fb_cyc_i,          // frame buffer cycle
   output logic [7:0]                 fb_rdata_o,        // frame buffer read data
   output logic                       fb_rvalid_o,       // read data valid pulse
   input  wire logic [31:0]           mem_rdata_i,       // addressed byte of each plane
   output vpd_pkg::vpd_mem_wr_t       mem_wr_o,          // plane write toward memory
   input  wire logic [3:0]            plane_write_mask_i,// sequencer plane enables
   input  wire logic                  chain4_i,          // chain-4 addressing active
   output logic [7:0]                 latch_readback_o,  // selected read latch
   input  wire logic                  shift_load_i,      // video load of plane bytes
   input  wire logic [31:0]           shift_planes_i,    // video plane bytes
   input  wire logic                  shift_step_i,      // video transfer
   output logic [3:0]                 serial_o           // serial plane bits to palette
);
   import vpd_pkg::*;

   // control registers
   logic [3:0]      idx_r;         // controller_index field
   logic [7:0]      sr_color_r;    // set_reset_color
   logic [7:0]      sr_enable_r;   // set_reset_enable
   logic [7:0]      cmp_color_r;   // compare_color
   logic [7:0]      rot_op_r;      // rotate_and_logic_op
   logic [7:0]      rd_plane_r;    // read_plane_choice
   logic [7:0]      mode_r;        // access_mode_control
   logic [7:0]      cmp_incl_r;    // compare_plane_include
   logic [7:0]      bit_mask_r;    // write_bit_mask

   // decoded fields
   vpd_wmode_t      wmode;         // write mode
   vpd_func_t       func;          // combine function
   logic [2:0]      rot_cnt;       // rotate count
   logic            rmode;         // read mode
   logic            odd_even;      // odd/even addressing

   // datapath signals
   logic [3:0][7:0] latch_r;       // memory read latches
   logic [3:0][7:0] mem_pl;        // memory read data per plane
   logic [15:0]     rot16;         // doubled data for rotation
   logic [7:0]      rot_d;         // rotated host data
   logic [7:0]      src_v;         // per plane source byte
   logic [7:0]      alu_v;         // per plane combined byte
   logic [7:0]      mask_v;        // per bit write mask
   logic [3:0][7:0] wr_plane;      // final plane write bytes
   logic [7:0]      cmp_res;       // color compare result
   logic [1:0]      plane_sel;     // effective read plane
   logic [7:0]      rd_data_nxt;   // frame buffer read data
   logic [7:0]      reg_rd_nxt;    // register read data
   logic            is_idx;        // cycle hits index port
   logic            is_data;       // cycle hits data port

   // field decode
   always_comb begin
      wmode    = vpd_wmode_t'(mode_r[MODE_WM_LSB +: 2]);
      func     = vpd_func_t'(rot_op_r[ROT_FN_LSB +: 2]);
      rot_cnt  = rot_op_r[ROT_CNT_LSB +: 3];
      rmode    = mode_r[MODE_RM_BIT];
      odd_even = mode_r[MODE_OE_BIT];
      mem_pl   = mem_rdata_i;
      is_idx   = (reg_cyc_i.addr == PORT_INDEX);
      is_data  = (reg_cyc_i.addr == PORT_DATA);
   end

   // index register write
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         idx_r <= 4'h0;
      end else if (reg_cyc_i.wr && is_idx) begin
         idx_r <= reg_cyc_i.data[3:0];
      end
   end

   // data port writes land in the indexed register, active from the next access
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         sr_color_r  <= RST_REG;
         sr_enable_r <= RST_REG;
         cmp_color_r <= RST_REG;
         rot_op_r    <= RST_REG;
         rd_plane_r  <= RST_REG;
         mode_r      <= RST_MODE;
         cmp_incl_r  <= RST_REG;
         bit_mask_r  <= RST_REG;
      end else if (reg_cyc_i.wr && is_data) begin
         case (idx_r)
            IDX_SET_RESET:  sr_color_r  <= reg_cyc_i.data & MASK_NIBBLE;
            IDX_SR_ENABLE:  sr_enable_r <= reg_cyc_i.data & MASK_NIBBLE;
            IDX_CMP_COLOR:  cmp_color_r <= reg_cyc_i.data & MASK_NIBBLE;
            IDX_ROTATE_OP:  rot_op_r    <= reg_cyc_i.data & MASK_ROTATE_OP;
            IDX_READ_PLANE: rd_plane_r  <= reg_cyc_i.data & MASK_READ_PL;
            IDX_MODE:       mode_r      <= reg_cyc_i.data & MASK_MODE;
            IDX_CMP_INCL:   cmp_incl_r  <= reg_cyc_i.data & MASK_NIBBLE;
            IDX_BIT_MASK:   bit_mask_r  <= reg_cyc_i.data;
            default: ;  // unimplemented index: write ignored
         endcase
      end
   end

   // register read mux, reserved bits already stored as zero
   always_comb begin
      reg_rd_nxt = 8'h00;
      if (is_idx) begin
         reg_rd_nxt = {4'h0, idx_r};
      end else if (is_data) begin
         case (idx_r)
            IDX_SET_RESET:  reg_rd_nxt = sr_color_r;
            IDX_SR_ENABLE:  reg_rd_nxt = sr_enable_r;
            IDX_CMP_COLOR:  reg_rd_nxt = cmp_color_r;
            IDX_ROTATE_OP:  reg_rd_nxt = rot_op_r;
            IDX_READ_PLANE: reg_rd_nxt = rd_plane_r;
            IDX_MODE:       reg_rd_nxt = mode_r;
            IDX_CMP_INCL:   reg_rd_nxt = cmp_incl_r;
            IDX_BIT_MASK:   reg_rd_nxt = bit_mask_r;
            default:        reg_rd_nxt = 8'h00;
         endcase
      end
   end

   // register read data, held until the next register read
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_cyc_i.rd) begin
         reg_rdata_o <= reg_rd_nxt;
      end
   end

   // write path: rotate, pick source, combine, then apply bit mask per plane
   always_comb begin
      rot16    = {fb_cyc_i.data, fb_cyc_i.data} >> rot_cnt;
      rot_d    = rot16[7:0];
      src_v    = 8'h00;
      alu_v    = 8'h00;
      mask_v   = 8'h00;
      wr_plane = '0;
      for (int p = 0; p < 4; p++) begin
         case (wmode)
            VPD_WM0: begin
               // enable set/reset only counts here
               src_v = sr_enable_r[p] ? {8{sr_color_r[p]}} : rot_d;
            end
            VPD_WM2: begin
               src_v = {8{fb_cyc_i.data[p]}};
            end
            VPD_WM3: begin
               src_v = {8{sr_color_r[p]}};
            end
            default: begin
               src_v = latch_r[p];
            end
         endcase
         case (func)
            VPD_FN_AND: alu_v = src_v & latch_r[p];
            VPD_FN_OR:  alu_v = src_v | latch_r[p];
            VPD_FN_XOR: alu_v = src_v ^ latch_r[p];
            default:    alu_v = src_v;
         endcase
         if (wmode == VPD_WM1) begin
            alu_v = latch_r[p];
         end
         mask_v      = (wmode == VPD_WM3) ? (rot_d & bit_mask_r) : bit_mask_r;
         wr_plane[p] = (alu_v & mask_v) | (latch_r[p] & ~mask_v);
      end
   end

   // plane write toward memory, one cycle after the host write
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         mem_wr_o <= '0;
      end else begin
         mem_wr_o.we <= fb_cyc_i.wr ? plane_write_mask_i : 4'h0;
         if (fb_cyc_i.wr) begin
            mem_wr_o.data <= wr_plane;
         end
      end
   end

   // read latches copy every frame buffer read unaltered
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         latch_r <= '0;
      end else if (fb_cyc_i.rd) begin
         latch_r <= mem_pl;
      end
   end

   // read path: compare and plane select
   always_comb begin
      for (int b = 0; b < 8; b++) begin
         cmp_res[b] = 1'b1;
         for (int p = 0; p < 4; p++) begin
            if (cmp_incl_r[p] && (mem_pl[p][b] != cmp_color_r[p])) begin
               cmp_res[b] = 1'b0;
            end
         end
      end
      if (chain4_i) begin
         plane_sel = fb_cyc_i.addr[1:0];
      end else if (odd_even) begin
         plane_sel = {rd_plane_r[1], fb_cyc_i.addr[0]};
      end else begin
         plane_sel = rd_plane_r[1:0];
      end
      rd_data_nxt = rmode ? cmp_res : mem_pl[plane_sel];
   end

   // host read data and its valid pulse
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         fb_rdata_o  <= 8'h00;
         fb_rvalid_o <= 1'b0;
      end else begin
         fb_rvalid_o <= fb_cyc_i.rd;
         if (fb_cyc_i.rd) begin
            fb_rdata_o <= rd_data_nxt;
         end
      end
   end

   // latch readback follows the raw plane select
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         latch_readback_o <= 8'h00;
      end else begin
         latch_readback_o <= latch_r[rd_plane_r[1:0]];
      end
   end

   // video serializer
   vpd_shifter u_shifter (
      .mclk_i   (mclk_i),
      .rst_b_i  (rst_b_i),
      .load_i   (shift_load_i),
      .planes_i (shift_planes_i),
      .step_i   (shift_step_i),
      .mode_i   (mode_r[MODE_SH_LSB +: 2]),
      .serial_o (serial_o)
   );

   // index read returns the stored index with upper bits zero
   a_index_read: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      reg_cyc_i.rd && is_idx |=> reg_rdata_o == {4'h0, $past(idx_r)})
      else $error("index readback wrong");

   // data port write reaches the indexed register
   a_mode_write: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      reg_cyc_i.wr && is_data && idx_r == IDX_MODE
      |=> mode_r == ($past(reg_cyc_i.data) & MASK_MODE))
      else $error("mode register not written through data port");

   // write mode 0 with set/reset enabled fills plane 0 with its color
   a_sr_fill: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      fb_cyc_i.wr && wmode == VPD_WM0 && sr_enable_r[0] && func == VPD_FN_COPY
      && bit_mask_r == 8'hFF
      |=> mem_wr_o.data[7:0] == {8{$past(sr_color_r[0])}})
      else $error("set/reset fill wrong");

   // write mode 3 masks with rotated data and bit mask
   a_wm3_mask: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      fb_cyc_i.wr && wmode == VPD_WM3 && func == VPD_FN_COPY
      |=> ((mem_wr_o.data[7:0] ^ $past(latch_r[0])) & ~($past(rot_d) & $past(bit_mask_r)))
          == 8'h00)
      else $error("write mode 3 touched masked bits");

   // write mode 2 ignores set/reset enables
   a_wm2_color: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      fb_cyc_i.wr && wmode == VPD_WM2 && func == VPD_FN_COPY
      |=> ((mem_wr_o.data[7:0] ^ {8{$past(fb_cyc_i.data[0])}}) & $past(bit_mask_r)) == 8'h00)
      else $error("write mode 2 color wrong");

   // xor function under the bit mask, plane 1 without set/reset
   a_func_xor: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      fb_cyc_i.wr && wmode == VPD_WM0 && !sr_enable_r[1] && func == VPD_FN_XOR
      |=> ((mem_wr_o.data[15:8] ^ $past(rot_d) ^ $past(latch_r[1])) & $past(bit_mask_r))
          == 8'h00)
      else $error("xor combine wrong");

   // write mode 1 stores the latches
   a_wm1_copy: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      fb_cyc_i.wr && wmode == VPD_WM1 |=> mem_wr_o.data == $past(latch_r))
      else $error("write mode 1 did not copy latches");

   // plane write pulse lasts one cycle and follows the plane enables
   a_write_pulse: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      fb_cyc_i.wr ##1 !fb_cyc_i.wr
      |-> mem_wr_o.we == $past(plane_write_mask_i) ##1 mem_wr_o.we == 4'h0)
      else $error("plane write pulse wrong");

   // read mode 1 with nothing included answers all ones
   a_cmp_empty: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      fb_cyc_i.rd && rmode && cmp_incl_r == 8'h00 |=> fb_rvalid_o && fb_rdata_o == 8'hFF)
      else $error("empty compare not all ones");

   // chain-4 read picks the plane by address
   a_chain4_sel: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      fb_cyc_i.rd && !rmode && chain4_i && fb_cyc_i.addr[1:0] == 2'h3
      |=> fb_rdata_o == $past(mem_rdata_i[31:24]))
      else $error("chain-4 plane select wrong");
endmodule : vpd_plane_datapath

// ===== src/vpd_pkg.sv
// package of constants and carrier types for the plane datapath
package vpd_pkg;
   // host register ports
   localparam logic [11:0] PORT_INDEX     = 12'h3CE;  // index port
   localparam logic [11:0] PORT_DATA      = 12'h3CF;  // data port
   // register indexes behind the data port
   localparam logic [3:0]  IDX_SET_RESET  = 4'h0;     // set_reset_color
   localparam logic [3:0]  IDX_SR_ENABLE  = 4'h1;     // set_reset_enable
   localparam logic [3:0]  IDX_CMP_COLOR  = 4'h2;     // compare_color
   localparam logic [3:0]  IDX_ROTATE_OP  = 4'h3;     // rotate_and_logic_op
   localparam logic [3:0]  IDX_READ_PLANE = 4'h4;     // read_plane_choice
   localparam logic [3:0]  IDX_MODE       = 4'h5;     // access_mode_control
   localparam logic [3:0]  IDX_CMP_INCL   = 4'h7;     // compare_plane_include
   localparam logic [3:0]  IDX_BIT_MASK   = 4'h8;     // write_bit_mask
   // writable bit masks, reserved bits kept at zero
   localparam logic [7:0]  MASK_NIBBLE    = 8'h0F;
   localparam logic [7:0]  MASK_ROTATE_OP = 8'h1F;
   localparam logic [7:0]  MASK_READ_PL   = 8'h03;
   localparam logic [7:0]  MASK_MODE      = 8'h7B;
   // reset values
   localparam logic [7:0]  RST_REG        = 8'h00;
   localparam logic [7:0]  RST_MODE       = 8'h00;
   // field positions
   localparam int          ROT_CNT_LSB    = 0;        // rotate count, 3 bits
   localparam int          ROT_FN_LSB     = 3;        // function select, 2 bits
   localparam int          MODE_WM_LSB    = 0;        // write mode, 2 bits
   localparam int          MODE_RM_BIT    = 3;        // read mode
   localparam int          MODE_OE_BIT    = 4;        // odd/even
   localparam int          MODE_SH_LSB    = 5;        // shift control, 2 bits
   // last shifter transfer number of a loaded group
   localparam logic [2:0]  SHIFT_LAST     = 3'h7;

   typedef enum logic [1:0] {
      VPD_WM0 = 2'h0,
      VPD_WM1 = 2'h1,
      VPD_WM2 = 2'h2,
      VPD_WM3 = 2'h3
   } vpd_wmode_t;

   typedef enum logic [1:0] {
      VPD_FN_COPY = 2'h0,
      VPD_FN_AND  = 2'h1,
      VPD_FN_OR   = 2'h2,
      VPD_FN_XOR  = 2'h3
   } vpd_func_t;

   // one host register or frame buffer cycle
   typedef struct packed {
      logic        wr;       // write strobe, one cycle
      logic        rd;       // read strobe, one cycle
      logic [11:0] addr;     // port address or low frame address bits
      logic [7:0]  data;     // write data
   } vpd_host_cyc_t;

   // one frame buffer write toward the four planes
   typedef struct packed {
      logic [3:0]  we;       // per plane write pulse
      logic [31:0] data;     // plane 3 in high byte
   } vpd_mem_wr_t;
endpackage : vpd_pkg

// ===== src/vpd_shifter.sv
// serializer of four plane bytes onto four serial outputs
`timescale 1ns/1ps
module vpd_shifter (
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   input  wire logic        load_i,      // capture plane bytes, resets transfer count
   input  wire logic [31:0] planes_i,    // plane n in bits 8n+7..8n
   input  wire logic        step_i,      // one transfer
   input  wire logic [1:0]  mode_i,      // shift control
   output logic      [3:0]  serial_o     // serial outputs, output n plane n in mode 00
);
   import vpd_pkg::*;

   logic [3:0][7:0] byte_r;    // held plane bytes
   logic [2:0]      xfer_r;    // transfer number within group
   logic [3:0]      out_nxt;   // next serial value
   logic [7:0]      pair_a;    // shifted plane for outputs 1..0 in mode 01
   logic [7:0]      pair_b;    // shifted plane for outputs 3..2 in mode 01
   logic [7:0]      nib_b;     // plane chosen in mode 1x

   // choose the bits of the current transfer
   always_comb begin
      // plane 0 then 1 on the low pair, plane 2 then 3 on the high pair
      pair_a  = byte_r[{1'b0, xfer_r[2]}] << {xfer_r[1:0], 1'b0};
      pair_b  = byte_r[{1'b1, xfer_r[2]}] << {xfer_r[1:0], 1'b0};
      nib_b   = byte_r[xfer_r[2:1]];
      out_nxt = 4'h0;
      case (mode_i)
         2'h0: begin
            // bit 7 first, one bit of each plane
            for (int n = 0; n < 4; n++) begin
               out_nxt[n] = byte_r[n][3'h7 - xfer_r];
            end
         end
         2'h1: begin
            // planes 0 and 2 first, then 1 and 3; odd bits on outputs 1 and 3
            out_nxt = {pair_b[7:6], pair_a[7:6]};
         end
         default: begin
            // high nibble then low nibble, plane 0 up to plane 3
            out_nxt = xfer_r[0] ? nib_b[3:0] : nib_b[7:4];
         end
      endcase
   end

   // plane byte capture
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         byte_r <= '0;
      end else if (load_i) begin
         byte_r <= planes_i;
      end
   end

   // transfer counter and output register
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         xfer_r   <= 3'h0;
         serial_o <= 4'h0;
      end else if (load_i) begin
         xfer_r <= 3'h0;
      end else if (step_i) begin
         serial_o <= out_nxt;
         xfer_r   <= (xfer_r == SHIFT_LAST) ? 3'h0 : xfer_r + 3'h1;
      end
   end

   // first transfer of mode 00 carries every plane's bit 7
   a_shift_msb_first: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      load_i ##1 (step_i && mode_i == 2'h0 && !load_i)
      |=> serial_o == {byte_r[3][7], byte_r[2][7], byte_r[1][7], byte_r[0][7]})
      else $error("shift mode 00 first transfer not msb");
endmodule : vpd_shifter

// ===== testbench/vpd_host_model.sv
// host processor model issuing register port and frame buffer cycles
`timescale 1ns/1ps
module vpd_host_model (
   input  wire logic              mclk_i,       // device clock
   output vpd_pkg::vpd_host_cyc_t reg_cyc_o,    // register port cycle
   output vpd_pkg::vpd_host_cyc_t fb_cyc_o      // frame buffer cycle
);
   import vpd_pkg::*;
   initial begin
      reg_cyc_o = '0;
      fb_cyc_o  = '0;
   end
   // one register strobe launched after a falling edge
   task automatic reg_cyc(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      reg_cyc_o = '{wr: w, rd: !w, addr: a, data: d};
   endtask : reg_cyc
   // release the port, a released bus shows inverted values
   task automatic idle;
      @(negedge mclk_i);
      reg_cyc_o = '{wr: 1'b0, rd: 1'b0, addr: ~reg_cyc_o.addr, data: ~reg_cyc_o.data};
   endtask : idle
   // index first, then data port; paging indexes never used here
   task automatic reg_wr(input logic [3:0] idx, input logic [7:0] v);
      reg_cyc(1'b1, PORT_INDEX, {4'h0, idx});
      reg_cyc(1'b1, PORT_DATA, v);
      idle();
   endtask : reg_wr
   // select then read the data port, answer lands one edge later
   task automatic reg_rd(input logic [3:0] idx, input logic [11:0] a, output logic [7:0] v);
      reg_cyc(1'b1, PORT_INDEX, {4'h0, idx});
      reg_cyc(1'b0, a, 8'h00);
      idle();
      v = test_vpd_plane_datapath.reg_rdata;
   endtask : reg_rd
   // one frame buffer access, answer visible on return
   task automatic fb_cyc(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      fb_cyc_o = '{wr: w, rd: !w, addr: a, data: d};
      @(negedge mclk_i);
      fb_cyc_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
   endtask : fb_cyc
endmodule : vpd_host_model

// ===== testbench/test_vpd_plane_datapath.sv
// self-checking bench of the plane datapath
`timescale 1ns/1ps
module test_vpd_plane_datapath;
   import vpd_pkg::*;
   localparam logic [31:0] PL = 32'h8C5A3FC1;  // plane bytes for reads
   logic          mclk = 1'b0, rst_b = 1'b0, chain4 = 1'b0, sh_load = 1'b0, sh_step = 1'b0;
   logic [31:0]   mem_rdata = '0;
   logic [7:0]    reg_rdata, fb_rdata, latch_rb;
   logic          fb_rvalid;
   logic [3:0]    serial;
   logic [3:0]    pmask = 4'hF;  // plane write enables
   vpd_host_cyc_t reg_cyc, fb_cyc;
   vpd_mem_wr_t   mem_wr;
   int            n_mismatch = 0, check_count = 0;
   always #10 mclk = ~mclk;
   vpd_host_model host (.mclk_i(mclk), .reg_cyc_o(reg_cyc), .fb_cyc_o(fb_cyc));
   vpd_plane_datapath dut (.mclk_i(mclk), .rst_b_i(rst_b), .reg_cyc_i(reg_cyc),
      .reg_rdata_o(reg_rdata), .fb_cyc_i(fb_cyc), .fb_rdata_o(fb_rdata),
      .fb_rvalid_o(fb_rvalid), .mem_rdata_i(mem_rdata), .mem_wr_o(mem_wr),
      .plane_write_mask_i(pmask), .chain4_i(chain4), .latch_readback_o(latch_rb),
      .shift_load_i(sh_load), .shift_planes_i(PL), .shift_step_i(sh_step),
      .serial_o(serial));
   // compare and count
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask : chk
   // expected plane bytes of one write
   function automatic logic [31:0] wexp(logic [1:0] wm, logic [1:0] fn, logic [2:0] rc,
      logic [3:0] sr, logic [3:0] esr, logic [7:0] bm, logic [7:0] d, logic [31:0] lat);
      logic [7:0] rot, s, a, m, l;
      rot = (d >> rc) | (d << (8 - rc));
      m = (wm == 2'h3) ? (rot & bm) : bm;
      for (int p = 0; p < 4; p++) begin
         l = lat[8*p+:8];
         case (wm)
            2'h0: s = esr[p] ? {8{sr[p]}} : rot;
            2'h1: s = l;
            2'h2: s = {8{d[p]}};
            default: s = {8{sr[p]}};
         endcase
         a = (fn == 2'h1) ? s & l : (fn == 2'h2) ? s | l : (fn == 2'h3) ? s ^ l : s;
         wexp[8*p+:8] = (wm == 2'h1) ? l : (a & m) | (l & ~m);
      end
   endfunction : wexp
   // program, load latches by a read, then write and judge
   task automatic do_write(input logic [1:0] wm, input logic [1:0] fn, input logic [2:0] rc,
      input logic [3:0] sr, input logic [3:0] esr, input logic [7:0] bm, input logic [7:0] d,
      input logic [31:0] lat);
      host.reg_wr(IDX_SET_RESET, {4'h0, sr});
      host.reg_wr(IDX_SR_ENABLE, {4'h0, esr});
      host.reg_wr(IDX_ROTATE_OP, {3'h0, fn, rc});
      host.reg_wr(IDX_BIT_MASK, bm);
      host.reg_wr(IDX_MODE, {6'h0, wm});
      mem_rdata = lat;
      host.fb_cyc(1'b0, 12'h000, 8'h00);
      mem_rdata = ~lat;
      host.fb_cyc(1'b1, 12'h000, d);
      chk("wr_data", wexp(wm, fn, rc, sr, esr, bm, d, lat), mem_wr.data);
      chk("wr_en", {28'h0, pmask}, {28'h0, mem_wr.we});
   endtask : do_write
   // reset values, reserved bits, index readback, unmapped port
   task automatic t_regs;
      logic [7:0] msk [10] = '{8'h0F, 8'h0F, 8'h0F, 8'h1F, 8'h03, 8'h7B, 8'h00, 8'h0F,
                               8'hFF, 8'h00};
      logic [7:0] v;
      for (int i = 0; i < 10; i++) begin
         host.reg_rd(i[3:0], PORT_DATA, v);
         chk("reset_val", 32'h0, v);
         host.reg_wr(i[3:0], 8'hFF);
         host.reg_rd(i[3:0], PORT_DATA, v);
         chk("reg_bits", msk[i], v);
      end
      host.reg_cyc(1'b1, PORT_INDEX, 8'hFF);
      host.reg_cyc(1'b0, PORT_INDEX, 8'h00);
      host.idle();
      chk("index", 32'h0F, {24'h0, reg_rdata});
      host.reg_rd(4'h8, 12'h3C0, v);
      chk("unmapped", 32'h0, v);
      $display("test regs done");
   endtask : t_regs
   // every write mode and logic function
   task automatic t_wmodes;
      do_write(2'h0, 2'h0, 3'h3, 4'h3, 4'h5, 8'hFF, 8'h81, 32'h11223344);
      for (int f = 1; f < 4; f++)
         do_write(2'h0, f[1:0], 3'h0, 4'h0, 4'h0, 8'h0F, 8'h96, 32'hA5C33CF0);
      pmask = 4'hA;
      do_write(2'h1, 2'h2, 3'h1, 4'hF, 4'hF, 8'h0F, 8'h55, 32'h12345678);
      pmask = 4'hF;
      do_write(2'h2, 2'h0, 3'h5, 4'h0, 4'hF, 8'hF0, 8'h05, 32'hCAFE0011);
      do_write(2'h3, 2'h0, 3'h2, 4'h9, 4'h6, 8'h7E, 8'hB4, 32'h0F0F0F0F);
      $display("test write modes done");
   endtask : t_wmodes
   // plane select, odd/even, chain-4, latch readback, compare
   task automatic t_reads;
      logic [7:0] e;
      mem_rdata = PL;
      host.reg_wr(IDX_MODE, 8'h00);
      for (int s = 0; s < 4; s++) begin
         host.reg_wr(IDX_READ_PLANE, s[7:0]);
         host.fb_cyc(1'b0, 12'h000, 8'h00);
         chk("rvalid", 32'h1, {31'h0, fb_rvalid});
         chk("rd_plane", PL[8*s+:8], fb_rdata);
         @(negedge mclk);
         chk("latch_rb", PL[8*s+:8], latch_rb);
      end
      host.reg_wr(IDX_MODE, 8'h10);
      host.fb_cyc(1'b0, 12'h000, 8'h00);
      chk("odd_even", PL[23:16], fb_rdata);
      chain4 = 1'b1;
      host.reg_wr(IDX_READ_PLANE, 8'h00);
      host.fb_cyc(1'b0, 12'h003, 8'h00);
      chk("chain4", PL[31:24], fb_rdata);
      chain4 = 1'b0;
      host.reg_wr(IDX_CMP_COLOR, 8'h0A);
      host.reg_wr(IDX_CMP_INCL, 8'h0B);
      host.reg_wr(IDX_MODE, 8'h08);
      host.fb_cyc(1'b0, 12'h000, 8'h00);
      e = 8'hFF;
      for (int p = 0; p < 4; p++)
         if (p != 2)
            e &= (p == 0) ? ~PL[7:0] : PL[8*p+:8];
      chk("compare", e, fb_rdata);
      host.reg_wr(IDX_CMP_INCL, 8'h00);
      host.fb_cyc(1'b0, 12'h000, 8'h00);
      chk("cmp_none", 32'hFF, fb_rdata);
      $display("test reads done");
   endtask : t_reads
   // serializer in each shift control setting
   task automatic t_shift;
      logic [3:0] e;
      logic [7:0] b;
      int         j, q;
      for (int m = 0; m < 4; m++) begin
         host.reg_wr(IDX_MODE, {1'b0, m[1:0], 5'h00});
         @(negedge mclk);
         sh_load = 1'b1;
         @(negedge mclk);
         sh_load = 1'b0;
         for (int k = 0; k < 8; k++) begin
            sh_step = 1'b1;
            @(negedge mclk);
            sh_step = 1'b0;
            @(negedge mclk);
            j = k % 4;
            q = (k < 4) ? 0 : 8;
            b = PL[8*(k/2)+:8];
            if (m == 0)
               e = {PL[31-k], PL[23-k], PL[15-k], PL[7-k]};
            else if (m == 1)
               e = {PL[q+23-2*j], PL[q+22-2*j], PL[q+7-2*j], PL[q+6-2*j]};
            else
               e = k[0] ? b[3:0] : b[7:4];
            chk("serial", e, serial);
         end
      end
      $display("test shifter done");
   endtask : t_shift
   // counts and verdict
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (8) @(negedge mclk);
      rst_b = 1'b1;
      t_regs();
      t_wmodes();
      t_reads();
      t_shift();
      print_verdict();
   end
   // watchdog well beyond the expected run
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      print_verdict();
   end
endmodule : test_vpd_plane_datapath
